// ==== hdl/add_logic_jump_compare_exec.v ====
// Executes add, add with carry, page jump, logical AND and compare-branch
`include "exec_defines.vh"
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// [RQ1] Add with carry sums acc, source and carry; sets CY and AC from bits 7, 3.
// [RQ2] Overflow set when exactly one of carries out of bits 6 and 7 occurs.
// [RQ3] Add direct byte: opcode 25h plus address, 2 bytes, 2 cycles.
// [RQ4] Add indirect via pointer register: opcode 0010011i, 1 byte, 1 cycle.
// [RQ5] Add with carry working register: opcode 00111rrr, 1 byte, 1 cycle.
// [RQ6] Page jump: pc plus two, low 11 bits replaced; 2 bytes, 3 cycles.
// [RQ7] Byte AND stores result, flags untouched; acc or direct destination forms.
// [RQ8] AND to a port reads the output latch, not the pins.
// [RQ9] AND acc with direct byte: opcode 55h, 2 bytes, 2 cycles.
// [RQ10] AND direct with acc into direct: opcode 52h, 2 bytes, 2 cycles.
// [RQ11] AND direct with immediate: opcode 53h, 3 bytes, 3 cycles.
// [RQ12] Bit AND clears carry on zero source; complemented form; direct bit only.
// [RQ13] Carry AND bit: opcode 82h plus bit address, 2 bytes, 2 cycles.
// [RQ14] Compare branches when unequal to advanced pc plus signed displacement.
// [RQ15] Compare sets carry when first operand is unsigned less; operands kept.
// [RQ16] Compare acc with direct: opcode B5h, 3 bytes, 4 cycles.
// [RQ17] Compare acc with direct or immediate, indirect or register with immediate.
// [RQ18] Add working register: opcode 00101rrr, 1 byte, 1 cycle.
// [RQ19] AND acc with working register: opcode 01011rrr, 1 byte, 1 cycle.
module add_logic_jump_compare_exec (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Program memory
  output reg [15:0] code_addr_q,
  input wire [7:0] code_data,
  // Internal data and special registers
  output reg [7:0] data_addr_q,
  output reg data_rd_q,
  output reg data_latch_q,
  input wire [7:0] data_rdata,
  output reg data_wr_q,
  output reg [7:0] data_wdata_q,
  // Bit space
  output reg [7:0] bit_addr_q,
  input wire bit_rdata,
  // Working registers of the current bank
  input wire [63:0] working_register,
  input wire [1:0] bank_sel,
  // Architectural state
  output reg [15:0] program_counter_q,
  output reg [7:0] acc_q,
  output reg [7:0] psw_q,
  output reg illegal_q,
  output reg retire_q
);
  localparam S_FETCH = 3'd0;
  localparam S_OPER1 = 3'd1;
  localparam S_OPER2 = 3'd2;
  localparam S_READ = 3'd3;
  localparam S_EXEC = 3'd4;
  localparam S_WAIT = 3'd5;

  localparam K_NONE = 3'd0;
  localparam K_ADD = 3'd1;
  localparam K_ADD_WITH_CARRY_TO_ACC = 3'd2;
  localparam K_AND = 3'd3;
  localparam K_ANDD = 3'd4;
  localparam K_CMP = 3'd5;
  localparam K_JMP = 3'd6;
  localparam K_BIT = 3'd7;

  localparam M_REG = 2'd0;
  localparam M_DIR = 2'd1;
  localparam M_IND = 2'd2;
  localparam M_IMM = 2'd3;

  reg [2:0] state_q, state_d;
  reg [7:0] op_q;
  reg [7:0] b1_q;
  reg [7:0] b2_q;
  reg [7:0] mem_q;
  reg [2:0] cyc_q;
  reg [2:0] kind;
  reg [1:0] mode;
  reg [1:0] len;
  reg [2:0] cycles;
  reg bit_inv;
  wire [7:0] wreg [0:7];
  wire [7:0] sel_reg;
  wire [7:0] src;
  wire [7:0] sum;
  wire cy, ac, ov;
  wire [15:0] pc_adv;
  wire [15:0] page_target;
  wire [15:0] rel_target;
  wire [7:0] cmp_a;
  wire [7:0] cmp_b;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_wreg
      assign wreg[gi] = working_register[gi*8 +: 8];
    end
  endgenerate

  // Decode of the held opcode
  always @* begin
    kind = K_NONE;
    mode = M_REG;
    len = 2'd1;
    cycles = `CYC_ONE;
    bit_inv = 1'b0;
    if (op_q[7:3] == `OP_ADD_REG) begin
      kind = K_ADD; // [RQ18]
    end else if (op_q == `OP_ADD_DIR) begin
      kind = K_ADD; // [RQ3]
      mode = M_DIR;
      len = 2'd2;
      cycles = `CYC_TWO;
    end else if (op_q[7:1] == `OP_ADD_IND) begin
      kind = K_ADD; // [RQ4]
      mode = M_IND;
    end else if (op_q == `OP_ADD_IMM) begin
      kind = K_ADD;
      mode = M_IMM;
      len = 2'd2;
      cycles = `CYC_TWO;
    end else if (op_q[7:3] == `OP_ADD_WITH_CARRY_TO_ACC_REG) begin
      kind = K_ADD_WITH_CARRY_TO_ACC; // [RQ5]
    end else if (op_q == `OP_ADD_WITH_CARRY_TO_ACC_DIR) begin
      kind = K_ADD_WITH_CARRY_TO_ACC;
      mode = M_DIR;
      len = 2'd2;
      cycles = `CYC_TWO;
    end else if (op_q[7:1] == `OP_ADD_WITH_CARRY_TO_ACC_IND) begin
      kind = K_ADD_WITH_CARRY_TO_ACC;
      mode = M_IND;
    end else if (op_q == `OP_ADD_WITH_CARRY_TO_ACC_IMM) begin
      kind = K_ADD_WITH_CARRY_TO_ACC;
      mode = M_IMM;
      len = 2'd2;
      cycles = `CYC_TWO;
    end else if (op_q[4:0] == `OP_JUMP_LOW) begin
      kind = K_JMP; // [RQ6]
      len = 2'd2;
      cycles = `CYC_THREE;
    end else if (op_q[7:3] == `OP_AND_REG) begin
      kind = K_AND; // [RQ19]
    end else if (op_q == `OP_AND_DIR) begin
      kind = K_AND; // [RQ9]
      mode = M_DIR;
      len = 2'd2;
      cycles = `CYC_TWO;
    end else if (op_q[7:1] == `OP_AND_IND) begin
      kind = K_AND; // [RQ7]
      mode = M_IND;
    end else if (op_q == `OP_AND_IMM) begin
      kind = K_AND; // [RQ7]
      mode = M_IMM;
      len = 2'd2;
      cycles = `CYC_TWO;
    end else if (op_q == `OP_AND_DIR_ACC) begin
      kind = K_ANDD; // [RQ10]
      mode = M_DIR;
      len = 2'd2;
      cycles = `CYC_TWO;
    end else if (op_q == `OP_AND_DIR_IMM) begin
      kind = K_ANDD; // [RQ11]
      mode = M_IMM;
      len = 2'd3;
      cycles = `CYC_THREE;
    end else if (op_q == `OP_AND_C_BIT) begin
      kind = K_BIT; // [RQ13]
      len = 2'd2;
      cycles = `CYC_TWO;
    end else if (op_q == `OP_AND_C_NBIT) begin
      kind = K_BIT; // [RQ12]
      len = 2'd2;
      cycles = `CYC_TWO;
      bit_inv = 1'b1;
    end else if (op_q == `OP_CMP_DIR) begin
      kind = K_CMP; // [RQ16]
      mode = M_DIR;
      len = 2'd3;
      cycles = `CYC_FOUR;
    end else if (op_q == `OP_CMP_IMM) begin
      kind = K_CMP; // [RQ17]
      mode = M_IMM;
      len = 2'd3;
      cycles = `CYC_FOUR;
    end else if (op_q[7:1] == `OP_CMP_IND) begin
      kind = K_CMP; // [RQ17]
      mode = M_IND;
      len = 2'd3;
      cycles = `CYC_FOUR;
    end else if (op_q[7:3] == `OP_CMP_REG) begin
      kind = K_CMP; // [RQ17]
      mode = M_REG;
      len = 2'd3;
      cycles = `CYC_FOUR;
    end
  end

  assign sel_reg = wreg[op_q[2:0]];
  // Immediate sits in byte 1, except for the three-byte direct forms
  assign src = (mode == M_REG) ? sel_reg :
               (mode == M_IMM) ? b1_q : mem_q;

  byte_adder u_add (
    .a(acc_q),
    .b(src),
    .cin((kind == K_ADD_WITH_CARRY_TO_ACC) ? psw_q[`FLAG_CY] : 1'b0), // [RQ1]
    .sum(sum),
    .cy(cy),
    .ac(ac),
    .ov(ov)
  );

  assign pc_adv = program_counter_q + {14'h0000, len};
  assign cmp_a = (mode == M_IND || (mode == M_REG)) ?
                 ((mode == M_REG) ? sel_reg : mem_q) : acc_q;
  assign cmp_b = (mode == M_DIR) ? mem_q : b1_q;

  branch_target u_tgt (
    .pc_next(pc_adv),
    .page_hi(op_q[7:5]),
    .low_byte(b1_q),
    .rel(b2_q),
    .page_target(page_target),
    .rel_target(rel_target)
  );

  // Sequencer
  always @* begin
    state_d = state_q;
    case (state_q)
      S_FETCH: state_d = S_OPER1;
      S_OPER1: begin
        if (len == 2'd1)
          state_d = (mode == M_IND) ? S_READ : S_EXEC;
        else
          state_d = S_OPER2;
      end
      S_OPER2: begin
        if (len == 2'd3 && cyc_q == 3'd0)
          state_d = S_OPER2;
        else if (mode == M_DIR || mode == M_IND || kind == K_ANDD)
          state_d = S_READ;
        else
          state_d = S_EXEC;
      end
      S_READ: state_d = S_EXEC;
      S_EXEC: state_d = (cyc_q + 3'd1 < cycles) ? S_WAIT : S_FETCH;
      S_WAIT: state_d = (cyc_q + 3'd1 < cycles) ? S_WAIT : S_FETCH;
      default: state_d = S_FETCH;
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= S_FETCH;
      op_q <= 8'h00;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
      mem_q <= 8'h00;
      cyc_q <= 3'h0;
      code_addr_q <= `PC_RESET;
      program_counter_q <= `PC_RESET;
      acc_q <= `ACC_RESET;
      psw_q <= `PSW_RESET;
      data_addr_q <= 8'h00;
      data_rd_q <= 1'b0;
      data_latch_q <= 1'b0;
      data_wr_q <= 1'b0;
      data_wdata_q <= 8'h00;
      bit_addr_q <= 8'h00;
      illegal_q <= 1'b0;
      retire_q <= 1'b0;
    end else begin
      state_q <= state_d;
      data_rd_q <= 1'b0;
      data_wr_q <= 1'b0;
      retire_q <= 1'b0;
      case (state_q)
        S_FETCH: begin
          op_q <= code_data;
          cyc_q <= 3'h0;
          code_addr_q <= program_counter_q + 16'h0001;
        end
        S_OPER1: begin
          b1_q <= code_data;
          code_addr_q <= program_counter_q + 16'h0002;
          if (mode == M_IND) begin
            data_addr_q <= wreg[{2'b00, op_q[0]}];
            data_rd_q <= 1'b1;
          end
          if (kind == K_BIT)
            bit_addr_q <= code_data;
        end
        S_OPER2: begin
          if (len == 2'd3 && cyc_q == 3'd0) begin
            b2_q <= code_data;
            cyc_q <= 3'h1;
          end
          if (kind == K_BIT)
            bit_addr_q <= b1_q;
          if (mode == M_DIR || kind == K_ANDD) begin
            data_addr_q <= b1_q;
            data_rd_q <= 1'b1;
            // Read-modify-write takes the port latch, not the pins
            data_latch_q <= (kind == K_ANDD); // [RQ8]
          end
          if (mode == M_IND) begin
            data_addr_q <= wreg[{2'b00, op_q[0]}];
            data_rd_q <= 1'b1;
          end
        end
        S_READ: begin
          mem_q <= data_rdata;
        end
        S_EXEC: begin
          cyc_q <= cyc_q + 3'd1;
          case (kind)
            K_ADD, K_ADD_WITH_CARRY_TO_ACC: begin
              acc_q <= sum; // [RQ1]
              psw_q[`FLAG_CY] <= cy; // [RQ1]
              psw_q[`FLAG_AC] <= ac; // [RQ1]
              psw_q[`FLAG_OV] <= ov; // [RQ2]
            end
            K_AND: acc_q <= acc_q & src; // [RQ7]
            K_ANDD: begin
              data_wr_q <= 1'b1;
              data_latch_q <= 1'b0;
              // The immediate form carries the constant in byte 2
              data_wdata_q <= mem_q & ((mode == M_IMM) ? b2_q : acc_q); // [RQ7]
            end
            K_BIT: begin
              if ((bit_rdata ^ bit_inv) == 1'b0)
                psw_q[`FLAG_CY] <= 1'b0; // [RQ12]
            end
            K_CMP: begin
              psw_q[`FLAG_CY] <= (cmp_a < cmp_b); // [RQ15]
            end
            // Jump only moves the program counter, below
            K_JMP: ;
            default: illegal_q <= 1'b1;
          endcase
          if (kind == K_JMP)
            program_counter_q <= page_target; // [RQ6]
          else if (kind == K_CMP && cmp_a != cmp_b)
            program_counter_q <= rel_target; // [RQ14]
          else
            program_counter_q <= pc_adv;
        end
        S_WAIT: cyc_q <= cyc_q + 3'd1;
        default: ;
      endcase
      if (state_d == S_FETCH && state_q != S_FETCH) begin
        retire_q <= 1'b1;
        code_addr_q <= (state_q == S_EXEC) ?
                       ((kind == K_JMP) ? page_target :
                        (kind == K_CMP && cmp_a != cmp_b) ? rel_target : pc_adv) :
                       program_counter_q;
      end
    end
  end
endmodule
`default_nettype wire

// ==== shared/exec_defines.vh ====
// Opcode encodings, cycle counts, flag positions and reset values
`ifndef EXEC_DEFINES_VH
`define EXEC_DEFINES_VH
`define OP_ADD_DIR 8'h25
`define OP_ADD_IMM 8'h24
`define OP_ADD_IND 7'h13
`define OP_ADD_REG 5'h05
`define OP_ADD_WITH_CARRY_TO_ACC_DIR 8'h35
`define OP_ADD_WITH_CARRY_TO_ACC_IMM 8'h34
`define OP_ADD_WITH_CARRY_TO_ACC_IND 7'h1b
`define OP_ADD_WITH_CARRY_TO_ACC_REG 5'h07
`define OP_JUMP_LOW 5'h01
`define OP_AND_DIR 8'h55
`define OP_AND_IMM 8'h54
`define OP_AND_IND 7'h2b
`define OP_AND_REG 5'h0b
`define OP_AND_DIR_ACC 8'h52
`define OP_AND_DIR_IMM 8'h53
`define OP_AND_C_BIT 8'h82
`define OP_AND_C_NBIT 8'hb0
`define OP_CMP_DIR 8'hb5
`define OP_CMP_IMM 8'hb4
`define OP_CMP_IND 7'h5b
`define OP_CMP_REG 5'h17
`define CYC_ONE 3'h1
`define CYC_TWO 3'h2
`define CYC_THREE 3'h3
`define CYC_FOUR 3'h4
`define FLAG_CY 7
`define FLAG_AC 6
`define FLAG_OV 2
`define PC_RESET 16'h0000
`define ACC_RESET 8'h00
`define PSW_RESET 8'h00
`endif

// ==== hdl/byte_adder.v ====
// Eight-bit adder with carry, auxiliary carry and overflow
`timescale 1ns/100ps
`default_nettype none
module byte_adder (
  // Operands
  input wire [7:0] a,
  input wire [7:0] b,
  input wire cin,
  // Result
  output wire [7:0] sum,
  output wire cy,
  output wire ac,
  output wire ov
);
  wire [4:0] low;
  wire [3:0] mid;
  wire [1:0] top;
  assign low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
  assign mid = {1'b0, a[6:4]} + {1'b0, b[6:4]} + {3'h0, low[4]};
  assign top = {1'b0, a[7]} + {1'b0, b[7]} + {1'b0, mid[3]};
  assign sum = {top[0], mid[2:0], low[3:0]};
  assign cy = top[1]; // [RQ1]
  assign ac = low[4]; // [RQ1]
  // Exactly one of carry out of bit 6 and bit 7
  assign ov = top[1] ^ mid[3]; // [RQ2]
endmodule
`default_nettype wire

// ==== hdl/branch_target.v ====
// Page jump and relative branch address formation
`timescale 1ns/100ps
`default_nettype none
module branch_target (
  // Advanced program counter and instruction fields
  input wire [15:0] pc_next,
  input wire [2:0] page_hi,
  input wire [7:0] low_byte,
  input wire [7:0] rel,
  // Targets
  output wire [15:0] page_target,
  output wire [15:0] rel_target
);
  // Upper five bits of pc plus two kept, so the jump stays in the 2K page of the next instruction
  assign page_target = {pc_next[15:11], page_hi, low_byte}; // [RQ6]
  assign rel_target = pc_next + {{8{rel[7]}}, rel}; // [RQ14]
endmodule
`default_nettype wire

// ==== verification/exec_checker_sva.sv ====
// Checker of the execute block at its ports
`timescale 1ns/100ps
`default_nettype none
module exec_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Observed ports
  input wire logic [15:0] code_addr_q,
  input wire logic [7:0] code_data,
  input wire logic data_rd_q,
  input wire logic data_latch_q,
  input wire logic [15:0] program_counter_q,
  input wire logic [7:0] acc_q,
  input wire logic [7:0] psw_q,
  input wire logic retire_q
);
  logic go_q, st, cin, add_op, cmp_op;
  logic [7:0] op_q, b1_q, b2_q, a_q, p_q;
  logic [15:0] pc_q, pc2;
  logic [8:0] sum;
  logic [4:0] nib;
  assign st = go_q | retire_q;
  assign cin = (op_q == 8'h34) & p_q[7];
  assign add_op = retire_q && (op_q == 8'h24 || op_q == 8'h34);
  assign cmp_op = retire_q && op_q == 8'hb4;
  assign sum = a_q + b1_q + cin;
  assign nib = a_q[3:0] + b1_q[3:0] + cin;
  assign pc2 = pc_q + 16'h2;
  // Snapshot at each opcode fetch; operands caught as they are fetched
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      go_q <= 1'b1;
      {op_q, b1_q, b2_q, a_q, p_q, pc_q} <= '0;
    end else begin
      go_q <= 1'b0;
      if (st) {op_q, a_q, p_q, pc_q} <= {code_data, acc_q, psw_q, code_addr_q};
      if (code_addr_q == pc_q + 16'h1) b1_q <= code_data;
      if (code_addr_q == pc2) b2_q <= code_data;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_add_sum; add_op |-> {psw_q[7], acc_q} == sum; endproperty
  a_add_sum: assert property (p_add_sum) else $error("add sum or carry wrong");
  property p_add_aux; add_op |-> psw_q[6] == nib[4]; endproperty
  a_add_aux: assert property (p_add_aux) else $error("aux carry wrong");
  property p_add_ov; add_op |-> psw_q[2] == (a_q[7] == b1_q[7] && acc_q[7] != a_q[7]); endproperty
  a_add_ov: assert property (p_add_ov) else $error("overflow wrong");
  property p_add_len; retire_q && op_q == 8'h25 |-> program_counter_q == pc2; endproperty
  a_add_len: assert property (p_add_len) else $error("direct add length wrong");
  property p_jump; retire_q && op_q[4:0] == 5'h01 |-> program_counter_q == {pc2[15:11], op_q[7:5], b1_q}; endproperty
  a_jump: assert property (p_jump) else $error("page jump target wrong");
  property p_and_flags; retire_q && op_q[7:4] == 4'h5 && op_q[3:0] > 4'h1 |-> (psw_q & 8'hc4) == (p_q & 8'hc4); endproperty
  a_and_flags: assert property (p_and_flags) else $error("byte and changed flags");
  property p_latch; data_rd_q && !st && (op_q == 8'h52 || op_q == 8'h53) |-> data_latch_q; endproperty
  a_latch: assert property (p_latch) else $error("modify read took pins");
  property p_cmp_c; cmp_op |-> psw_q[7] == (a_q < b1_q) && acc_q == a_q; endproperty
  a_cmp_c: assert property (p_cmp_c) else $error("compare carry or operand wrong");
  property p_cmp_pc; cmp_op |-> program_counter_q == pc_q + 16'h3 + (a_q != b1_q ? {{8{b2_q[7]}}, b2_q} : 16'h0); endproperty
  a_cmp_pc: assert property (p_cmp_pc) else $error("compare branch target wrong");
  c_taken: cover property (cmp_op && a_q != b1_q);
  c_jump: cover property (retire_q && op_q[4:0] == 5'h01);
  c_latch: cover property (data_rd_q && data_latch_q);
endmodule
bind add_logic_jump_compare_exec exec_checker i_chk (.clk, .rst_b, .code_addr_q, .code_data,
  .data_rd_q, .data_latch_q, .program_counter_q, .acc_q, .psw_q, .retire_q);
`default_nettype wire

// ==== verification/mem_model.sv ====
// Program memory, data memory, port pins and bit space
`timescale 1ns/100ps
`default_nettype none
module mem_model (
  // Clock
  input wire logic clk,
  // Program memory
  input wire logic [15:0] code_addr_q,
  output logic [7:0] code_data,
  // Data space
  input wire logic [7:0] data_addr_q,
  input wire logic data_rd_q,
  input wire logic data_latch_q,
  output wire logic [7:0] data_rdata,
  input wire logic data_wr_q,
  input wire logic [7:0] data_wdata_q,
  // Bit space
  input wire logic [7:0] bit_addr_q,
  output logic bit_rdata
);
  logic [7:0] code [2048];
  logic [7:0] ram [256];
  logic [7:0] pins;
  logic [255:0] bits;
  logic [7:0] rd_val;
  assign code_data = code[code_addr_q[10:0]];
  assign bit_rdata = bits[bit_addr_q];
  // Read data stands while the strobe does; inverted outside it so a late sample shows
  assign rd_val = (data_addr_q == 8'h90 && !data_latch_q) ? pins : ram[data_addr_q];
  assign data_rdata = data_rd_q ? rd_val : ~rd_val;
  always @(posedge clk) begin
    if (data_wr_q) ram[data_addr_q] <= data_wdata_q;
  end
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench of the execute block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk, rst_b, data_rd_q, data_latch_q, data_wr_q, bit_rdata, illegal_q, retire_q, chk;
  logic [15:0] code_addr_q, program_counter_q, pc;
  logic [7:0] code_data, data_addr_q, data_rdata, data_wdata_q, bit_addr_q, acc_q, psw_q;
  logic [7:0] acc, psw, ca, cv, o, b1, b2;
  logic [63:0] working_register;
  logic [1:0] bank_sel;
  logic [7:0] ops [17] = '{8'h24, 8'h25, 8'h26, 8'h2b, 8'h34, 8'h35, 8'h3e, 8'h52, 8'h53,
    8'h54, 8'h55, 8'h5c, 8'h82, 8'hb0, 8'hb4, 8'hb5, 8'h61};
  int miscompares, num_checks;
  int cycles = 0;
  add_logic_jump_compare_exec i_dut (.clk, .rst_b, .code_addr_q, .code_data, .data_addr_q,
    .data_rd_q, .data_latch_q, .data_rdata, .data_wr_q, .data_wdata_q, .bit_addr_q,
    .bit_rdata, .working_register, .bank_sel, .program_counter_q, .acc_q, .psw_q,
    .illegal_q, .retire_q);
  mem_model i_mem (.clk, .code_addr_q, .code_data, .data_addr_q, .data_rd_q, .data_latch_q,
    .data_rdata, .data_wr_q, .data_wdata_q, .bit_addr_q, .bit_rdata);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hang guard, far above the expected run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      complete_run;
    end
  end
  task automatic check(input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [10:0] addf(input logic [7:0] a, b, input logic c);
    logic [8:0] s;
    logic [7:0] m;
    logic [4:0] n;
    s = a + b + c;
    m = a[6:0] + b[6:0] + c;
    n = a[3:0] + b[3:0] + c;
    return {s[8], n[4], s[8] ^ m[7], s[7:0]};
  endfunction
  // Expected effect of one instruction; port reads see pins except for 52h and 53h, indirect never does
  task automatic model(input logic [7:0] o, b1, b2);
    logic [7:0] s;
    s = o[3] ? working_register[8*o[2:0] +: 8] : o[2:1] == 2'h3 ?
      i_mem.ram[working_register[8*o[0] +: 8]] : !o[0] ? b1 : b1 == 8'h90 ? i_mem.pins : i_mem.ram[b1];
    chk = 1'b0;
    pc = pc + (o[3:0] > 4'h5 ? 16'h1 : (o == 8'h53 || o[7:1] == 7'h5a) ? 16'h3 : 16'h2);
    if (o[4:0] == 5'h01) pc = {pc[15:11], o[7:5], b1};
    else if (o[7:5] == 3'h1) {psw[7], psw[6], psw[2], acc} = addf(acc, s, o[4] & psw[7]);
    else if (o == 8'h52 || o == 8'h53) begin
      {chk, ca} = {1'b1, b1};
      cv = i_mem.ram[b1] & (o[0] ? b2 : acc);
    end else if (o[7:4] == 4'h5) acc = acc & s;
    else if (o == 8'h82 || o == 8'hb0) psw[7] = psw[7] & (i_mem.bits[b1] ^ o[4]);
    else begin
      psw[7] = acc < s;
      if (acc != s) pc = pc + {{8{b2[7]}}, b2};
    end
  endtask
  // Place next instruction, wait for the previous one to retire, check it
  task automatic step(input logic [7:0] o, b1, b2);
    int n;
    i_mem.code[11'(pc)] = o;
    i_mem.code[11'(pc + 16'h1)] = b1;
    i_mem.code[11'(pc + 16'h2)] = b2;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (retire_q !== 1'b1 && n < 40);
    check({15'h0, retire_q}, 16'h1);
    check(program_counter_q, pc);
    check({acc_q, psw_q & 8'hc4}, {acc, psw});
    if (chk) check({8'h0, i_mem.ram[ca]}, {8'h0, cv});
    working_register = {$urandom, $urandom & 32'hffff_7f7f};
    model(o, b1, b2);
  endtask
  initial begin
    {rst_b, working_register, bank_sel, chk, acc, psw} = '0;
    {miscompares, num_checks, pc} = {32'h0, 32'h0, 16'h2};
    void'($urandom(32'h68d1));
    foreach (i_mem.ram[i]) i_mem.ram[i] = 8'($urandom);
    i_mem.bits = {8{$urandom}};
    i_mem.pins = 8'h3c;
    i_mem.code[0] = 8'h24;
    i_mem.code[1] = 8'h00;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    step(8'h24, 8'h7f, 8'h00);
    step(8'h34, 8'hff, 8'h00);
    step(8'h34, 8'h00, 8'h00);
    step(8'h53, 8'h90, 8'h5a);
    step(8'h52, 8'h90, 8'h00);
    step(8'hb4, acc, 8'h40);
    step(8'hb4, acc + 8'h1, 8'hb0);
    step(8'h54, 8'h0f, 8'h00);
    step(8'h82, 8'h20, 8'h00);
    step(8'hb0, 8'h20, 8'h00);
    step(8'hc1, 8'h7e, 8'h00);
    $display("test corner done");
    repeat (150) begin
      o = ops[$urandom % 17];
      b1 = 8'($urandom) & 8'h7f;
      b2 = 8'($urandom);
      if (o[4:0] == 5'h01) o[7:5] = ~pc[10:8];
      if (o[7:1] == 7'h5a) b2[6] = ~b2[7];
      step(o, b1, b2);
    end
    step(8'h24, 8'h00, 8'h00);
    check({15'h0, illegal_q}, 16'h0);
    $display("test random done");
    complete_run;
  end
endmodule
`default_nettype wire
